//--- shared/smbus_defs.svh
`ifndef SMBUS_DEFS_SVH
`define SMBUS_DEFS_SVH

// Fixed 7-bit target address (0101000)
`define TARGET_ADDR        7'h28
// Byte framing
`define BITS_PER_BYTE      4'h8
`define PTR_RESET          8'h00
`define PTR_STEP           8'h01

// Core clock rate and documented times
`define CORE_CLK_HZ        10_000_000
`define BOOT_TIME_MS       15
`define CLK_LOW_TIMEOUT_MS 30
`define IDLE_TIME_US       200

// Cycle counts at the core clock rate
`define BOOT_CYCLES        ((`BOOT_TIME_MS * `CORE_CLK_HZ) / 1000)
`define LOW_TO_CYCLES      ((`CLK_LOW_TIMEOUT_MS * `CORE_CLK_HZ) / 1000)
`define IDLE_CYCLES        ((`IDLE_TIME_US * `CORE_CLK_HZ) / 1000000)

// Width of the long counters
`define CNT_W              19
// Link-side glitch filter: samples a pin must stay changed
`define FILTER_SAMPLES     3'h4
`define FILT_W             3

`endif

//--- shared/smbus_pkg.sv
`include "smbus_defs.svh"

package smbus_pkg;

	// Protocol states of the target engine
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_IGNORE
	} bus_state_t;

	// Link-domain state: pin sampling, filtering, data drive
	typedef struct packed {
		logic                             rst_m;
		logic                             rst_s;
		logic [1:0]                       pin_m;
		logic [1:0]                       pin_s;
		logic [1:0]                       pin_f;
		logic [1:0][`FILT_W-1:0]          filt_n;
		logic                             drv_m;
		logic                             drv_s;
		logic                             sda_oe;
		logic                             scl_oe;
	} link_state_t;

	// Core-domain state: protocol engine and register access
	typedef struct packed {
		logic                             scl_m;
		logic                             scl_s;
		logic                             scl_p;
		logic                             sda_m;
		logic                             sda_s;
		logic                             sda_p;
		bus_state_t                       st;
		logic [3:0]                       bitcnt;
		logic [7:0]                       sh;
		logic [7:0]                       txbuf;
		logic                             rw;
		logic                             first;
		logic                             have_reg;
		logic                             pend_v;
		logic [7:0]                       pend;
		logic [7:0]                       ptr;
		logic                             drive;
		logic                             awake;
		logic                             reg_wr;
		logic                             reg_rd;
		logic [7:0]                       reg_addr;
		logic [7:0]                       reg_wdata;
		logic                             ready;
		logic [`CNT_W-1:0]                boot_cnt;
		logic [`CNT_W-1:0]                low_cnt;
		logic [`CNT_W-1:0]                idle_cnt;
	} core_state_t;

endpackage : smbus_pkg

//--- verilog/smbus_register_slave.sv
// Overview of operation
// - Answer only the 7-bit target address 0101000 in the address byte.
// - Eighth address bit gives direction: 0 host writes, 1 host reads.
// - Every byte is eight bits, most significant bit first, both ways.
// - Acknowledge each received byte by pulling data low in the ninth slot.
// - Start is data falling while clock is high.
// - Stop (data rising, clock high) resets the target logic.
// - With timeout enabled, clock low for 30 ms resets the interface.
// - Timeout and idle reset start disabled; an enable input turns them on.
// - With enable set, clock and data high over 200 us resets the protocol.
// - Tolerate clock stretching; never drive the clock line low.
// - Multi-byte transfers carry no count byte and run until the host ends.
// - Write byte: address, register address, data, each acked, then stop.
// - Read byte: set register address, repeated start, read one byte, NACK.
// - Address write plus one register byte then stop only loads the pointer.
// - Bare read returns the register at the current pointer, repeatable.
// - Pointer-only and bare-read transactions fail while deep sleep is selected.
// - Ignore all bus traffic for 15 ms after reset.
// - Pointer increments after each written byte and each host-acked read byte, and wraps from FFh to 00h.
// - Addressed traffic wakes the device; deep sleep select stays set.

`include "smbus_defs.svh"

module smbus_register_slave #(
	parameter logic [`CNT_W-1:0] BOOT_CYC   = `CNT_W'(`BOOT_CYCLES),
	parameter logic [`CNT_W-1:0] LOW_TO_CYC = `CNT_W'(`LOW_TO_CYCLES)
) (
	input  wire logic       core_clk,
	input  wire logic       ce,
	input  wire logic       srst,
	input  wire logic       link_clk,
	input  wire logic       serial_clock_pin,
	output logic            serial_clock_pin_o,
	output logic            serial_clock_pin_oe,
	input  wire logic       serial_data_pin,
	output logic            serial_data_pin_o,
	output logic            serial_data_pin_oe,
	input  wire logic       timeout_en,
	input  wire logic       deep_sleep_select,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr_strobe,
	output logic            reg_rd_strobe,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            wake
);
	import smbus_pkg::*;

	localparam logic [`CNT_W-1:0] IDLE_CYC = `CNT_W'(`IDLE_CYCLES);
	localparam int              SCL_IDX  = 0;
	localparam int              SDA_IDX  = 1;

	localparam link_state_t LINK_RST = '{
		pin_m:  2'h3,
		pin_s:  2'h3,
		pin_f:  2'h3,
		default: '0
	};

	localparam core_state_t CORE_RST = '{
		scl_m: 1'b1,
		scl_s: 1'b1,
		scl_p: 1'b1,
		sda_m: 1'b1,
		sda_s: 1'b1,
		sda_p: 1'b1,
		st:    ST_IDLE,
		ptr:   `PTR_RESET,
		default: '0
	};

	link_state_t lk_q;
	link_state_t lk_d;
	core_state_t c_q;
	core_state_t c_d;

	logic scl_rise;
	logic scl_fall;
	logic start_evt;
	logic stop_evt;
	logic low_hit;
	logic idle_hit;
	logic addr_ok;
	logic [7:0] wr_addr;

	// Link side: pin synchronisers, glitch filter, data drive
	always_comb
	begin
		lk_d = lk_q;
		lk_d.pin_m = {serial_data_pin, serial_clock_pin};
		lk_d.pin_s = lk_q.pin_m;
		for (int i = 0; i < 2; i++)
		begin
			if (lk_q.pin_s[i] == lk_q.pin_f[i])
				lk_d.filt_n[i] = '0;
			else if (lk_q.filt_n[i] == `FILTER_SAMPLES - 3'h1)
			begin
				lk_d.pin_f[i] = lk_q.pin_s[i];
				lk_d.filt_n[i] = '0;
			end
			else
				lk_d.filt_n[i] = lk_q.filt_n[i] + 3'h1;
		end
		lk_d.drv_m = c_q.drive;
		lk_d.drv_s = lk_q.drv_m;
		lk_d.sda_oe = lk_q.drv_s;
		lk_d.scl_oe = 1'b0;
		if (lk_q.rst_s)
			lk_d = LINK_RST;
		lk_d.rst_m = srst;
		lk_d.rst_s = lk_q.rst_m;
	end

	// Link-side register
	always_ff @(posedge link_clk)
	begin
		lk_q <= lk_d;
	end

	// Bus events seen in the core domain
	assign scl_rise  = c_q.scl_s & ~c_q.scl_p;
	assign scl_fall  = ~c_q.scl_s & c_q.scl_p;
	assign start_evt = c_q.scl_s & c_q.scl_p & c_q.sda_p & ~c_q.sda_s;
	assign stop_evt  = c_q.scl_s & c_q.scl_p & ~c_q.sda_p & c_q.sda_s;
	assign low_hit   = timeout_en & ~c_q.scl_s & (c_q.low_cnt == LOW_TO_CYC);
	assign idle_hit  = timeout_en & c_q.scl_s & c_q.sda_s & (c_q.idle_cnt == IDLE_CYC);
	assign addr_ok   = (c_q.sh[7:1] == `TARGET_ADDR)
		&& !(c_q.sh[0] && deep_sleep_select && !c_q.have_reg);
	assign wr_addr   = c_q.pend_v ? c_q.pend : c_q.ptr;

	// Core side: protocol engine
	always_comb
	begin
		c_d = c_q;
		c_d.reg_wr = 1'b0;
		c_d.reg_rd = 1'b0;
		c_d.scl_m = lk_q.pin_f[SCL_IDX];
		c_d.scl_s = c_q.scl_m;
		c_d.scl_p = c_q.scl_s;
		c_d.sda_m = lk_q.pin_f[SDA_IDX];
		c_d.sda_s = c_q.sda_m;
		c_d.sda_p = c_q.sda_s;
		if (c_q.reg_rd)
			c_d.txbuf = reg_rdata;

		if (!timeout_en || c_q.scl_s || low_hit)
			c_d.low_cnt = '0;
		else
			c_d.low_cnt = c_q.low_cnt + `CNT_W'(1);
		if (!timeout_en || !(c_q.scl_s && c_q.sda_s) || idle_hit)
			c_d.idle_cnt = '0;
		else
			c_d.idle_cnt = c_q.idle_cnt + `CNT_W'(1);

		if (!c_q.ready)
		begin
			if (c_q.boot_cnt == BOOT_CYC - `CNT_W'(1))
				c_d.ready = 1'b1;
			else
				c_d.boot_cnt = c_q.boot_cnt + `CNT_W'(1);
			c_d.st = ST_IDLE;
			c_d.drive = 1'b0;
		end
		else if (stop_evt || low_hit || idle_hit)
		begin
			c_d.st = ST_IDLE;
			c_d.drive = 1'b0;
			c_d.awake = 1'b0;
			c_d.have_reg = 1'b0;
			// pointer-only held in deep sleep dropped
			c_d.pend_v = 1'b0;
		end
		else if (start_evt)
		begin
			// Repeated start commits a held pointer
			if (c_q.pend_v)
			begin
				c_d.ptr = c_q.pend;
				c_d.have_reg = 1'b1;
				c_d.pend_v = 1'b0;
			end
			c_d.st = ST_ADDR;
			c_d.bitcnt = '0;
			c_d.drive = 1'b0;
		end
		else
		begin
			unique case (c_q.st)
				ST_IDLE, ST_IGNORE:
				begin
					c_d.drive = 1'b0;
				end
				ST_ADDR, ST_RX:
				begin
					if (scl_rise)
					begin
						c_d.sh = {c_q.sh[6:0], c_q.sda_s};
						c_d.bitcnt = c_q.bitcnt + 4'h1;
					end
					else if (scl_fall && c_q.bitcnt == `BITS_PER_BYTE && c_q.st == ST_ADDR)
					begin
						if (addr_ok)
						begin
							c_d.rw = c_q.sh[0];
							c_d.drive = 1'b1;
							c_d.awake = 1'b1;
							c_d.st = ST_ADDR_ACK;
							if (c_q.sh[0])
							begin
								c_d.reg_rd = 1'b1;
								c_d.reg_addr = c_q.ptr;
							end
						end
						else
							c_d.st = ST_IGNORE;
					end
					else if (scl_fall && c_q.bitcnt == `BITS_PER_BYTE)
					begin
						c_d.drive = 1'b1;
						c_d.st = ST_RX_ACK;
						c_d.first = 1'b0;
						if (c_q.first && deep_sleep_select)
						begin
							c_d.pend = c_q.sh;
							c_d.pend_v = 1'b1;
						end
						else if (c_q.first)
						begin
							c_d.ptr = c_q.sh;
							c_d.have_reg = 1'b1;
						end
						else
						begin
							c_d.reg_wr = 1'b1;
							c_d.reg_addr = wr_addr;
							c_d.reg_wdata = c_q.sh;
							c_d.ptr = wr_addr + `PTR_STEP;
							c_d.pend_v = 1'b0;
							c_d.have_reg = 1'b1;
						end
					end
				end
				ST_ADDR_ACK:
				begin
					if (scl_fall && c_q.rw)
					begin
						c_d.sh = c_q.txbuf;
						c_d.drive = ~c_q.txbuf[7];
						c_d.bitcnt = '0;
						c_d.st = ST_TX;
					end
					else if (scl_fall)
					begin
						c_d.drive = 1'b0;
						c_d.bitcnt = '0;
						c_d.first = 1'b1;
						c_d.st = ST_RX;
					end
				end
				ST_RX_ACK:
				begin
					if (scl_fall)
					begin
						c_d.drive = 1'b0;
						c_d.bitcnt = '0;
						c_d.st = ST_RX;
					end
				end
				ST_TX:
				begin
					if (scl_rise)
						c_d.bitcnt = c_q.bitcnt + 4'h1;
					else if (scl_fall && c_q.bitcnt == `BITS_PER_BYTE)
					begin
						c_d.drive = 1'b0;
						c_d.st = ST_TX_ACK;
					end
					else if (scl_fall)
					begin
						c_d.sh = {c_q.sh[6:0], 1'b0};
						c_d.drive = ~c_q.sh[6];
					end
				end
				ST_TX_ACK:
				begin
					if (scl_rise && c_q.sda_s)
						c_d.st = ST_IGNORE;
					else if (scl_rise)
					begin
						c_d.reg_rd = 1'b1;
						c_d.reg_addr = c_q.ptr + `PTR_STEP;
						c_d.ptr = c_q.ptr + `PTR_STEP;
					end
					else if (scl_fall)
					begin
						c_d.sh = c_q.txbuf;
						c_d.drive = ~c_q.txbuf[7];
						c_d.bitcnt = '0;
						c_d.st = ST_TX;
					end
				end
			endcase
		end
	end

	// Core-side register, frozen while ce is low
	always_ff @(posedge core_clk)
	begin
		if (srst)
			c_q <= CORE_RST;
		else if (ce)
			c_q <= c_d;
	end

	// Outputs straight from flops; pin data outputs tied low
	assign serial_clock_pin_o  = 1'b0;
	assign serial_clock_pin_oe = lk_q.scl_oe;
	assign serial_data_pin_o   = 1'b0;
	assign serial_data_pin_oe  = lk_q.sda_oe;
	assign reg_wr_strobe       = c_q.reg_wr;
	assign reg_rd_strobe       = c_q.reg_rd;
	assign reg_addr            = c_q.reg_addr;
	assign reg_wdata           = c_q.reg_wdata;
	assign wake                = c_q.awake;

	// Clock line never driven
	clk_never_driven_a: assert property (
		@(posedge link_clk) disable iff (lk_q.rst_s)
		!serial_clock_pin_oe)
		else $error("clock line driven");

	// Address acknowledge only for own address
	addr_ack_match_a: assert property (
		@(posedge core_clk) disable iff (srst)
		(ce && c_q.st == ST_ADDR && c_d.st == ST_ADDR_ACK)
			|=> (c_q.drive && $past(c_q.sh[7:1]) == `TARGET_ADDR))
		else $error("acked foreign address");

	// Data sent only after read direction
	dir_read_a: assert property (
		@(posedge core_clk) disable iff (srst)
		(c_q.st == ST_ADDR_ACK && c_d.st == ST_TX) |-> c_q.rw)
		else $error("transmit on write direction");

	// Ack only after eight bits
	ack_eight_bits_a: assert property (
		@(posedge core_clk) disable iff (srst)
		(ce && !c_q.drive && c_d.drive && (c_q.st == ST_ADDR || c_q.st == ST_RX))
			|-> c_q.bitcnt == `BITS_PER_BYTE)
		else $error("ack before eighth bit");

	// Start enters address phase
	start_enters_a: assert property (
		@(posedge core_clk) disable iff (srst)
		(ce && c_q.ready && start_evt && !stop_evt && !low_hit && !idle_hit)
			|=> c_q.st == ST_ADDR && !c_q.drive)
		else $error("start not taken");

	// Stop releases the bus
	stop_release_a: assert property (
		@(posedge core_clk) disable iff (srst)
		(ce && stop_evt) |=> (c_q.st == ST_IDLE && !c_q.drive && !c_q.awake))
		else $error("stop did not reset");

	// Timeouts reset the engine
	timeout_reset_a: assert property (
		@(posedge core_clk) disable iff (srst)
		(ce && (low_hit || idle_hit)) |=> (c_q.st == ST_IDLE && c_q.low_cnt == '0))
		else $error("timeout did not reset");

	// Counters stay clear while disabled
	timeout_off_a: assert property (
		@(posedge core_clk) disable iff (srst)
		!timeout_en[*2] |-> (c_q.low_cnt == '0 && c_q.idle_cnt == '0))
		else $error("timeout counting while disabled");

	// Blackout keeps the bus untouched
	boot_quiet_a: assert property (
		@(posedge core_clk) disable iff (srst)
		!c_q.ready |-> (c_q.st == ST_IDLE && !c_q.drive && !c_q.reg_wr))
		else $error("traffic served during blackout");

	// Pointer steps past each written byte
	ptr_step_a: assert property (
		@(posedge core_clk) disable iff (srst)
		c_q.reg_wr |-> c_q.ptr == c_q.reg_addr + `PTR_STEP)
		else $error("pointer not incremented");

	// Bare read refused in deep sleep
	sleep_bare_read_a: assert property (
		@(posedge core_clk) disable iff (srst)
		(c_q.st == ST_ADDR && c_d.st == ST_ADDR_ACK && c_q.sh[0] && deep_sleep_select)
			|-> c_q.have_reg)
		else $error("bare read in deep sleep");

endmodule : smbus_register_slave

//--- tb/bus_host.sv
module bus_host (
	input  wire logic clk_oe,
	input  wire logic data_oe,
	output wire logic scl,
	output wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clock high and data setup time, and data hold after the clock falls
	localparam int T = 2000;
	localparam int H = 500;

	logic scl_low = 1'b0;
	logic sda_low = 1'b0;

	// Open-drain lines with pull-ups
	assign scl = ~(scl_low | clk_oe);
	assign sda = ~(sda_low | data_oe);

	task start;
		#H;
		sda_low = 1'b0;
		#T;
		scl_low = 1'b0;
		#T;
		sda_low = 1'b1;
		#T;
		scl_low = 1'b1;
	endtask : start

	task stop;
		#H;
		sda_low = 1'b1;
		#T;
		scl_low = 1'b0;
		#T;
		sda_low = 1'b0;
		#T;
	endtask : stop

	// eight bits msb first, then the ack slot
	task xfer(input logic [7:0] d, input logic slot, output logic [7:0] q, output logic ack);
		logic [8:0] b;
		b = {d, slot};
		for (int i = 8; i >= 0; i--)
		begin
			#H;
			sda_low = ~b[i];
			#T;
			scl_low = 1'b0;
			#T;
			b[i] = sda;
			scl_low = 1'b1;
		end
		q = b[8:1];
		ack = b[0];
	endtask : xfer
endmodule : bus_host

//--- tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic            core_clk = 1'b0;
	logic            link_clk = 1'b0;
	logic            srst = 1'b1;
	logic            timeout_en = 1'b0;
	logic            deep_sleep_select = 1'b0;
	logic [7:0]      reg_rdata = 8'h00;
	logic [7:0]      mem [256];
	int              exp_mem [256];
	int              n_errors = 0;
	int              comparisons = 0;
	logic [31:0]     rs = 32'hc241;
	logic [7:0]      q;
	logic [7:0]      a;
	logic            k;
	wire logic       scl;
	wire logic       sda;
	wire logic       scl_o;
	wire logic       scl_oe;
	wire logic       sda_o;
	wire logic       sda_oe;
	wire logic       wr_s;
	wire logic       rd_s;
	wire logic       wake;
	wire logic [7:0] ra;
	wire logic [7:0] wd;

	// Core clock, 100 ns
	initial forever #50 core_clk = ~core_clk;

	// Link clock, 15 ns, unrelated phase
	initial
	begin
		#3;
		forever #7.5 link_clk = ~link_clk;
	end

	smbus_register_slave #(.BOOT_CYC(19'd200), .LOW_TO_CYC(19'd200)) uut (
		.core_clk           (core_clk),
		.ce                 (1'b1),
		.srst               (srst),
		.link_clk           (link_clk),
		.serial_clock_pin   (scl),
		.serial_clock_pin_o (scl_o),
		.serial_clock_pin_oe(scl_oe),
		.serial_data_pin    (sda),
		.serial_data_pin_o  (sda_o),
		.serial_data_pin_oe (sda_oe),
		.timeout_en         (timeout_en),
		.deep_sleep_select  (deep_sleep_select),
		.reg_rdata          (reg_rdata),
		.reg_wr_strobe      (wr_s),
		.reg_rd_strobe      (rd_s),
		.reg_addr           (ra),
		.reg_wdata          (wd),
		.wake               (wake)
	);

	bus_host host (.clk_oe(scl_oe), .data_oe(sda_oe), .scl(scl), .sda(sda));

	// Register file: write at the edge, read data set up inside the strobe cycle
	always @(posedge core_clk)
	begin
		if (wr_s)
			mem[ra] <= wd;
		#1;
		if (rd_s)
			reg_rdata = mem[ra];
	end

	function automatic logic [7:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[7:0];
	endfunction : rnd

	task chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task results;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	task tick;
		@(posedge core_clk);
		#1;
	endtask : tick

	task wr_regs(input logic [7:0] ad, input int n);
		logic [7:0] d;
		host.start();
		host.xfer(8'h50, 1'b1, q, k);
		chk(k, 1'b0);
		chk(wake, 1'b1);
		host.xfer(ad, 1'b1, q, k);
		chk(k, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			d = rnd();
			exp_mem[8'(ad + i)] = d;
			host.xfer(d, 1'b1, q, k);
			chk(k, 1'b0);
		end
		host.stop();
		chk(wake, 1'b0);
		for (int i = 0; i < n; i++)
			chk(mem[8'(ad + i)], 8'(exp_mem[8'(ad + i)]));
	endtask : wr_regs

	task rd_regs(input logic [7:0] ad, input int n, input logic setp);
		if (setp)
		begin
			host.start();
			host.xfer(8'h50, 1'b1, q, k);
			host.xfer(ad, 1'b1, q, k);
		end
		host.start();
		host.xfer(8'h51, 1'b1, q, k);
		chk(k, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			host.xfer(8'hff, i == n - 1, q, k);
			chk(q, 8'(exp_mem[8'(ad + i)]));
		end
		host.stop();
	endtask : rd_regs

	// Run limit
	initial
	begin
		#9_000_000;
		n_errors++;
		results();
	end

	// Main sequence
	initial
	begin
		for (int i = 0; i < 256; i++)
		begin
			mem[i] = rnd();
			exp_mem[i] = mem[i];
		end
		mem[16] = 8'h00;
		exp_mem[16] = 0;
		repeat (8) @(posedge core_clk);
		#1;
		srst = 1'b0;
		repeat (230) @(posedge core_clk);
		a = rnd() | 8'h80;
		wr_regs(a, 1);
		rd_regs(a, 1, 1'b1);
		$display("single byte test done");
		wr_regs(8'hfe, 3);
		rd_regs(8'hfd, 5, 1'b1);
		$display("block wrap test done");
		for (int b = 0; b < 7; b++)
		begin
			host.start();
			host.xfer({7'h28 ^ (7'h01 << b), 1'b0}, 1'b1, q, k);
			chk(k, 1'b1);
			host.stop();
		end
		$display("foreign address test done");
		host.start();
		host.xfer(8'h50, 1'b1, q, k);
		host.xfer(a, 1'b1, q, k);
		host.stop();
		rd_regs(a, 1, 1'b0);
		rd_regs(a, 1, 1'b0);
		$display("pointer test done");
		tick();
		deep_sleep_select = 1'b1;
		wr_regs(8'h40, 1);
		host.start();
		host.xfer(8'h50, 1'b1, q, k);
		host.xfer(8'(a + 9), 1'b1, q, k);
		host.stop();
		host.start();
		host.xfer(8'h51, 1'b1, q, k);
		chk(k, 1'b1);
		host.stop();
		tick();
		deep_sleep_select = 1'b0;
		rd_regs(8'h41, 1, 1'b0);
		$display("deep sleep test done");
		for (int e = 0; e < 2; e++)
		begin
			tick();
			timeout_en = (e == 1);
			host.start();
			host.xfer(8'h50, 1'b1, q, k);
			host.xfer(8'h10, 1'b1, q, k);
			host.start();
			host.xfer(8'h51, 1'b1, q, k);
			#30000;
			chk(sda, e == 1);
			chk(wake, e == 0);
			chk({scl_oe, scl_o, sda_o}, 8'h00);
			if (e == 0)
			begin
				host.xfer(8'hff, 1'b1, q, k);
				chk(q, 8'h00);
			end
			host.stop();
		end
		$display("clock low timeout test done");
		// Both lines left high mid-transfer with timeout enabled
		host.start();
		host.xfer(8'h50, 1'b1, q, k);
		chk(wake, 1'b1);
		#500;
		host.sda_low = 1'b0;
		#2000;
		host.scl_low = 1'b0;
		#250000;
		chk(wake, 1'b0);
		host.stop();
		$display("idle reset test done");
		// Reset in mid-run, then traffic inside the blackout
		tick();
		srst = 1'b1;
		repeat (8) tick();
		srst = 1'b0;
		host.start();
		host.xfer(8'h50, 1'b1, q, k);
		chk(k, 1'b1);
		host.stop();
		rd_regs(8'h10, 1, 1'b1);
		$display("blackout test done");
		results();
	end
endmodule : testbench
